/* File: hdl/clock_startup_consts.vh */
// Constants for the clock source selection and start-up timing block.
`ifndef CLOCK_STARTUP_CONSTS_VH
`define CLOCK_STARTUP_CONSTS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_CONFIG 4'h0
`define REG_GATE 4'h1
`define REG_STATUS 4'h2
`define REG_SOURCE 4'h3
// ----------------------------------------
// Clock source select codes, after inversion
// ----------------------------------------
`define SEL_EXTERNAL 4'h0
`define SEL_RC_8MHZ 4'h2
`define SEL_WATCHDOG 4'h4
`define SEL_LOW_FREQ 4'h6
// ----------------------------------------
// Source enumeration
// ----------------------------------------
`define SRC_EXTERNAL 3'h0
`define SRC_RC 3'h1
`define SRC_WATCHDOG 3'h2
`define SRC_LOW_FREQ 3'h3
`define SRC_CRYSTAL 3'h4
// ----------------------------------------
// Crystal amplifier ranges
// ----------------------------------------
`define AMP_RANGE_LOW 3'h4
`define AMP_RANGE_MID 3'h5
`define AMP_RANGE_HIGH 3'h6
`define AMP_RANGE_TOP 3'h7
// ----------------------------------------
// Raw fuse reset values: stored ones are unprogrammed
// ----------------------------------------
`define RAW_SOURCE_RESET 4'hD
`define RAW_STARTUP_RESET 2'h1
// The divide-by-eight fuse leaves the factory programmed, so it rests at zero.
`define RAW_DIV8_RESET 1'h0
// ----------------------------------------
// Start-up counts in source clock cycles
// ----------------------------------------
`define CK_6 15'h0006
`define CK_14 15'h000E
`define CK_258 15'h0102
`define CK_1K 15'h0400
`define CK_16K 15'h4000
`define CK_32K 15'h8000
// ----------------------------------------
// Watchdog time-outs in watchdog cycles
// ----------------------------------------
`define WDT_NONE 14'h0000
`define WDT_SHORT 14'h0200
`define WDT_LONG 14'h2000
`endif

/* File: hdl/clock_source_startup_control.v */
// Clock source decode, start-up hold-off and clock domain gating.
// Overview of operation
// - The four select bits decode to external, RC, watchdog, low-frequency or crystal source.
// - Every fuse bit is read inverted, a stored one meaning unprogrammed.
// - Wake from power-down counts source cycles before execution may start.
// - Start from reset adds a stabilisation delay counted on the watchdog oscillator.
// - The 4 ms delay is 512 watchdog cycles and the 64 ms delay is 8192.
// - The factory fuse values select the RC source, longest start-up and divide by eight.
// - For the crystal the upper three select bits give the amplifier range.
// - Crystal start-up uses the lowest select bit and the start-up bits, reset adds 14 cycles.
// - With the lowest bit zero the codes give 258, 258, 1K, 1K wake counts and matching delays.
// - With the lowest bit one the codes give 1K, 16K, 16K, 16K wake counts and matching delays.
// - Clocks of unused domains may be gated off under sleep control.
// - Gating the core clock stops all core operation.
// - The peripheral clock may stop while asynchronous interrupt detection keeps running.
// - The program memory clock runs whenever the core clock runs.
// - The converter clock runs on its own while core and peripheral clocks are stopped.
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "clock_startup_consts.vh"

module clock_source_startup_control #(
  // Cycles of the long reset delay; a bench may shorten it to save run time.
  parameter LONG_WDT_CYCLES = `WDT_LONG
) (
  // Clock, enable and reset
  input wire core_clk,
  input wire clk_en,
  input wire rst,
  // Register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Cycle ticks from the source and watchdog oscillators, asynchronous
  input wire source_tick,
  input wire watchdog_tick,
  // Power events
  input wire wake_request,
  input wire async_irq_pin,
  // Clock enables and status outputs
  output reg core_clock_en,
  output reg peripheral_clock_en,
  output reg program_memory_clock_en,
  output reg converter_clock_en,
  output reg async_irq_seen,
  output reg run_ready
);

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  localparam ST_RESET_CK = 2'h0;
  localparam ST_RESET_WDT = 2'h1;
  localparam ST_RUN = 2'h2;
  localparam ST_WAKE = 2'h3;

  // Decode the inverted select code into a source; reserved codes fall to RC.
  function [2:0] decode_source;
    input [3:0] code;
    begin
      if (code[3]) begin
        decode_source = `SRC_CRYSTAL;
      end else begin
        case (code)
          `SEL_EXTERNAL: decode_source = `SRC_EXTERNAL;
          `SEL_RC_8MHZ: decode_source = `SRC_RC;
          `SEL_WATCHDOG: decode_source = `SRC_WATCHDOG;
          `SEL_LOW_FREQ: decode_source = `SRC_LOW_FREQ;
          default: decode_source = `SRC_RC;
        endcase
      end
    end
  endfunction

  // Raw fuse storage, held as stored levels.
  reg [3:0] raw_source_q;
  reg [1:0] raw_startup_q;
  reg raw_div8_q;
  // Sleep gating controls; a one stops the domain.
  reg halt_core_q;
  reg halt_periph_q;
  reg halt_conv_q;
  reg [1:0] state_q;
  reg [14:0] ck_count_q;
  reg [13:0] wdt_count_q;
  reg [14:0] ck_target_q;
  reg [13:0] wdt_target_q;
  // Synchronisers for the asynchronous inputs.
  reg [1:0] src_sync_q;
  reg [1:0] wdt_sync_q;
  reg [1:0] irq_sync_q;
  reg [1:0] wake_sync_q;
  reg src_prev_q;
  reg wdt_prev_q;

  wire [3:0] sel_code;
  wire [1:0] sut_code;
  wire div8_active;
  wire [2:0] source;
  wire src_edge;
  wire wdt_edge;
  wire wake_done;
  reg [14:0] wake_count;
  reg [14:0] reset_ck;
  reg [13:0] reset_wdt;

  // Fuses are stored with one meaning unprogrammed, so the code is inverted.
  assign sel_code = ~raw_source_q;
  assign sut_code = ~raw_startup_q;
  assign div8_active = ~raw_div8_q;
  assign source = decode_source(sel_code);
  assign src_edge = src_sync_q[1] & ~src_prev_q;
  assign wdt_edge = wdt_sync_q[1] & ~wdt_prev_q;
  // The wake count has run out in this cycle.
  assign wake_done = (state_q == ST_WAKE) && (ck_count_q >= ck_target_q);

  // ----------------------------------------
  // Start-up table lookup
  // ----------------------------------------
  // Select the wake count, reset cycle count and watchdog delay for this setting.
  always @* begin
    wake_count = `CK_6;
    reset_ck = `CK_14;
    reset_wdt = `WDT_NONE;
    if (source == `SRC_CRYSTAL) begin
      case ({sel_code[0], sut_code})
        3'h0: begin wake_count = `CK_258; reset_wdt = `WDT_SHORT; end
        3'h1: begin wake_count = `CK_258; reset_wdt = LONG_WDT_CYCLES; end
        3'h2: begin wake_count = `CK_1K; end
        3'h3: begin wake_count = `CK_1K; reset_wdt = `WDT_SHORT; end
        3'h4: begin wake_count = `CK_1K; reset_wdt = LONG_WDT_CYCLES; end
        3'h5: begin wake_count = `CK_16K; end
        3'h6: begin wake_count = `CK_16K; reset_wdt = `WDT_SHORT; end
        default: begin wake_count = `CK_16K; reset_wdt = LONG_WDT_CYCLES; end
      endcase
    end else if (source == `SRC_LOW_FREQ) begin
      // The slow crystal needs no fixed cycle count ahead of the watchdog delay.
      reset_ck = 15'h0000;
      case (sut_code)
        2'h0: begin wake_count = `CK_1K; reset_wdt = `WDT_SHORT; end
        2'h1: begin wake_count = `CK_1K; reset_wdt = LONG_WDT_CYCLES; end
        default: begin wake_count = `CK_32K; reset_wdt = LONG_WDT_CYCLES; end
      endcase
    end else begin
      case (sut_code)
        2'h0: reset_wdt = `WDT_NONE;
        2'h1: reset_wdt = `WDT_SHORT;
        default: reset_wdt = LONG_WDT_CYCLES;
      endcase
    end
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Two flops on each pin; edge detection looks only at the second stage.
  always @(posedge core_clk) begin
    if (rst) begin
      src_sync_q <= 2'h0;
      wdt_sync_q <= 2'h0;
      irq_sync_q <= 2'h0;
      wake_sync_q <= 2'h0;
      src_prev_q <= 1'b0;
      wdt_prev_q <= 1'b0;
    end else if (clk_en) begin
      src_sync_q <= {src_sync_q[0], source_tick};
      wdt_sync_q <= {wdt_sync_q[0], watchdog_tick};
      irq_sync_q <= {irq_sync_q[0], async_irq_pin};
      wake_sync_q <= {wake_sync_q[0], wake_request};
      src_prev_q <= src_sync_q[1];
      wdt_prev_q <= wdt_sync_q[1];
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  // Writes load fuses and gating; reads answer one cycle later.
  always @(posedge core_clk) begin
    if (rst) begin
      raw_source_q <= `RAW_SOURCE_RESET;
      raw_startup_q <= `RAW_STARTUP_RESET;
      raw_div8_q <= `RAW_DIV8_RESET;
      halt_core_q <= 1'b0;
      halt_periph_q <= 1'b0;
      halt_conv_q <= 1'b0;
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == `REG_CONFIG) begin
        raw_source_q <= reg_wdata[3:0];
        raw_startup_q <= reg_wdata[5:4];
        raw_div8_q <= reg_wdata[6];
      end
      // Finishing a wake ends the core's sleep, else a held wake would re-enter at once.
      if (wake_done) begin
        halt_core_q <= 1'b0;
      end
      if (reg_wr && reg_addr == `REG_GATE) begin
        halt_core_q <= reg_wdata[0];
        halt_periph_q <= reg_wdata[1];
        halt_conv_q <= reg_wdata[2];
      end
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `REG_CONFIG: reg_rdata <= {1'b0, raw_div8_q, raw_startup_q, raw_source_q};
          `REG_GATE: reg_rdata <= {5'h00, halt_conv_q, halt_periph_q, halt_core_q};
          `REG_STATUS: reg_rdata <= {4'h0, async_irq_seen, run_ready, state_q};
          `REG_SOURCE: reg_rdata <= {div8_active, sel_code[3:1], 1'b0, source};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Start-up sequencer
  // ----------------------------------------
  // Reset waits source cycles then watchdog cycles; wake waits source cycles only.
  always @(posedge core_clk) begin
    if (rst) begin
      state_q <= ST_RESET_CK;
      ck_count_q <= 15'h0000;
      wdt_count_q <= 14'h0000;
      ck_target_q <= `CK_14;
      wdt_target_q <= 14'h0000;
      run_ready <= 1'b0;
    end else if (clk_en) begin
      case (state_q)
        ST_RESET_CK: begin
          // Targets are latched only while the count is idle, so a later write cannot cut it.
          if (ck_count_q == 15'h0000) begin
            ck_target_q <= reset_ck;
            wdt_target_q <= reset_wdt;
          end
          if (src_edge) begin
            ck_count_q <= ck_count_q + 15'h0001;
          end
          if (ck_count_q >= ck_target_q && ck_count_q != 15'h0000) begin
            state_q <= ST_RESET_WDT;
            wdt_count_q <= 14'h0000;
          end
        end
        ST_RESET_WDT: begin
          if (wdt_count_q >= wdt_target_q) begin
            state_q <= ST_RUN;
            run_ready <= 1'b1;
          end else if (wdt_edge) begin
            wdt_count_q <= wdt_count_q + 14'h0001;
          end
        end
        ST_RUN: begin
          if (wake_sync_q[1] && halt_core_q) begin
            state_q <= ST_WAKE;
            run_ready <= 1'b0;
            ck_count_q <= 15'h0000;
            ck_target_q <= wake_count;
          end
        end
        ST_WAKE: begin
          if (ck_count_q >= ck_target_q) begin
            state_q <= ST_RUN;
            run_ready <= 1'b1;
          end else if (src_edge) begin
            ck_count_q <= ck_count_q + 15'h0001;
          end
        end
        default: state_q <= ST_RESET_CK;
      endcase
    end
  end

  // ----------------------------------------
  // Domain clock enables
  // ----------------------------------------
  // The core stays stopped until start-up completes so no instruction runs early.
  always @(posedge core_clk) begin
    if (rst) begin
      core_clock_en <= 1'b0;
      peripheral_clock_en <= 1'b0;
      program_memory_clock_en <= 1'b0;
      converter_clock_en <= 1'b0;
      async_irq_seen <= 1'b0;
    end else if (clk_en) begin
      core_clock_en <= run_ready & ~halt_core_q;
      program_memory_clock_en <= run_ready & ~halt_core_q;
      peripheral_clock_en <= run_ready & ~halt_periph_q;
      converter_clock_en <= run_ready & ~halt_conv_q;
      // Caught regardless of the peripheral gate; cleared by the next core run.
      if (irq_sync_q[1]) begin
        async_irq_seen <= 1'b1;
      end else if (core_clock_en) begin
        async_irq_seen <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

/* File: verif/clock_startup_monitor.sv */
// Concurrent checks on the clock start-up block's ports.
`timescale 1ns/100ps
`default_nettype none
module clock_startup_monitor #(
  parameter LONG_WDT_CYCLES = 14'h2000
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Pins and enables
  input wire logic async_irq_pin,
  input wire logic core_clock_en,
  input wire logic peripheral_clock_en,
  input wire logic program_memory_clock_en,
  input wire logic converter_clock_en,
  input wire logic async_irq_seen,
  input wire logic run_ready
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_src_code; reg_rd && reg_addr == 4'h3 |=> reg_rdata[2:0] <= 3'h4; endproperty
  a_src_code: assert property (p_src_code) else $error("source code out of range");
  property p_wake_gate; $rose(core_clock_en) |-> $past(run_ready); endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("core clock before ready");
  property p_hold; $fell(rst) |-> !run_ready [*8]; endproperty
  a_hold: assert property (p_hold) else $error("ready too soon after reset");
  property p_gate; reg_wr && reg_addr == 4'h1 && reg_wdata[0] |-> ##[1:3] !core_clock_en;
  endproperty
  a_gate: assert property (p_gate) else $error("core clock not halted");
  property p_core_off; !run_ready && !$past(run_ready) |-> !core_clock_en; endproperty
  a_core_off: assert property (p_core_off) else $error("core clock while held");
  property p_irq; async_irq_pin [*3] |-> ##[0:2] async_irq_seen; endproperty
  a_irq: assert property (p_irq) else $error("interrupt not seen");
  property p_flash; program_memory_clock_en == core_clock_en; endproperty
  a_flash: assert property (p_flash) else $error("flash clock differs");
  property p_conv;
    reg_wr && reg_addr == 4'h1 && !reg_wdata[2] && run_ready |-> ##[1:3] converter_clock_en;
  endproperty
  a_conv: assert property (p_conv) else $error("converter clock stopped");
endmodule
bind clock_source_startup_control clock_startup_monitor #(.LONG_WDT_CYCLES(LONG_WDT_CYCLES))
  u_mon (.*);
`default_nettype wire

/* File: verif/osc_model.sv */
// Behavioural source and watchdog oscillators.
`timescale 1ns/100ps
`default_nettype none
module osc_model (
  // Clock
  input wire logic core_clk,
  // Oscillator ticks
  output logic source_tick,
  output logic watchdog_tick
);
  // A stopped oscillator rests low so it makes no stray edges.
  initial begin
    source_tick = 1'b0;
    watchdog_tick = 1'b0;
  end
  // Makes n rising edges, h core cycles per half period.
  task automatic src_edges(input int n, input int h);
    repeat (n) begin
      repeat (h) @(posedge core_clk);
      source_tick <= 1'b1;
      repeat (h) @(posedge core_clk);
      source_tick <= 1'b0;
    end
  endtask
  // Watchdog edges; the count stands for the real-time delay.
  task automatic wdt_edges(input int n, input int h);
    repeat (n) begin
      repeat (h) @(posedge core_clk);
      watchdog_tick <= 1'b1;
      repeat (h) @(posedge core_clk);
      watchdog_tick <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* File: verif/clock_source_startup_control_bench.sv */
// Self-checking bench for the clock start-up block.
`timescale 1ns/100ps
`default_nettype none
module clock_source_startup_control_bench;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic core_clk = 0, rst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0;
  logic wake_request = 0, async_irq_pin = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, v;
  wire logic [7:0] reg_rdata;
  wire logic source_tick, watchdog_tick, core_en, per_en, pm_en, conv_en, irq_seen, run_ready;
  int bad_count = 0, checks_done = 0;
  osc_model u_osc (.core_clk(core_clk), .source_tick(source_tick), .watchdog_tick(watchdog_tick));
  // The long delay is shortened to keep the run brief.
  clock_source_startup_control #(.LONG_WDT_CYCLES(14'h0010)) u_dut (.core_clk(core_clk),
    .clk_en(clk_en), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .source_tick(source_tick),
    .watchdog_tick(watchdog_tick), .wake_request(wake_request), .async_irq_pin(async_irq_pin),
    .core_clock_en(core_en), .peripheral_clock_en(per_en), .program_memory_clock_en(pm_en),
    .converter_clock_en(conv_en), .async_irq_seen(irq_seen), .run_ready(run_ready));
  // Clock generator.
  always #2 core_clk = ~core_clk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // Waits a bounded time for the ready flag, then judges it.
  task automatic wait_ready();
    for (int i = 0; i < 30 && run_ready !== 1'b1; i++) @(posedge core_clk);
    #1 check("run_ready", {7'h00, run_ready}, 8'h01);
  endtask
  task automatic settle_low(input string n);
    repeat (10) @(posedge core_clk);
    check(n, {7'h00, run_ready}, 8'h00);
  endtask
  // Loads a configuration, halts the core and wakes after n source edges.
  task automatic t_wake(input logic [7:0] cfg, input int n);
    wr(4'h0, cfg);
    wr(4'h1, 8'h01);
    wake_request <= 1'b1;
    u_osc.src_edges(n - 1, 2);
    settle_low("wake_early");
    u_osc.src_edges(1, 2);
    wait_ready();
    wake_request <= 1'b0;
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(4'h0);
    check("config", v, 8'h1D);
    rd(4'h3);
    check("source", v & 8'h87, 8'h81);
    rd(4'hF);
    check("unmapped", v, 8'h00);
  endtask
  task automatic t_startup();
    u_osc.src_edges(13, 2);
    settle_low("ck_phase");
    u_osc.src_edges(1, 2);
    u_osc.wdt_edges(15, 2);
    settle_low("wdt_phase");
    u_osc.wdt_edges(1, 2);
    wait_ready();
  endtask
  task automatic t_gate();
    wr(4'h1, 8'h03);
    repeat (4) @(posedge core_clk);
    check("gated", {core_en, per_en, pm_en, conv_en}, 8'h01);
    async_irq_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    async_irq_pin <= 1'b0;
    check("irq", {7'h00, irq_seen}, 8'h01);
  endtask
  // Crystal top range, lowest bit zero, start-up code 10 gives 1K wake edges.
  task automatic t_crystal();
    t_wake(8'h51, 1024);
    rd(4'h3);
    check("crystal", v & 8'h77, 8'h74);
    wr(4'h1, 8'h00);
    repeat (4) @(posedge core_clk);
    check("resume", {core_en, pm_en}, 8'h03);
  endtask
  // A reserved select code falls back to the RC source with 6 wake edges.
  task automatic t_reserved();
    t_wake(8'h5E, 6);
    rd(4'h3);
    check("fallback", v & 8'h07, 8'h01);
  endtask
  // A frozen enable must swallow a gate write; bit 0 stays clear so the core keeps running.
  task automatic t_freeze();
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(4'h1, 8'h06);
    clk_en <= 1'b1;
    rd(4'h1);
    check("frozen_gate", v, 8'h00);
  endtask
  // Main sequence: reset for six cycles, then the scenarios.
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_startup();
    t_gate();
    t_crystal();
    t_reserved();
    t_freeze();
    end_of_test();
  end
  // Watchdog well beyond the expected run of some four thousand three hundred cycles.
  initial begin
    #200000;
    bad_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
